// >>> hdl/ris_pkg.sv
// Package for the reset and initialisation sequencer.
// Assumes a single 10 MHz high-frequency clock drives all logic.
package ris_pkg;
   localparam logic [15:0] PC_VEC_MCU       = 16'hFFFE;
   localparam logic [15:0] PC_VEC_PROM      = 16'h1FFE;
   localparam logic [15:0] VEC_HI_ADDR      = 16'hFFFF;
   localparam logic [15:0] SP_RESET         = 16'h00FF;
   localparam logic [1:0]  RBS_RESET        = 2'h0;
   localparam logic [7:0]  PRESCALE_RESET   = 8'h00;
   localparam int          CLK_HZ           = 10_000_000;
   localparam int          WARMUP_CYC_DEF   = 4096;
   localparam int          NUM_INT_DEF      = 25;
   localparam int          NUM_PORT_DEF     = 8;
   typedef enum logic [1:0] {RIS_RESET, RIS_WARMUP, RIS_RUN} ris_state_t;
endpackage : ris_pkg

// >>> hdl/ris_ctl_if.sv
// Interface carrying the sequencer's hold state to its helper modules.
// Assumes all parties sit on the same clock.
`timescale 1ns/100ps
`default_nettype none
interface ris_ctl_if;
   logic hold;
   logic wu_clear;
   logic wu_done;
   modport seq  (output hold, output wu_clear, input wu_done);
   modport cnt  (input wu_clear, output wu_done);
   modport sync (input hold);
endinterface : ris_ctl_if
`default_nettype wire

// >>> hdl/ris_warmup_cnt.sv
// Warm-up counter on the high-frequency clock.
// Assumes wu_clear is high whenever any reset source is active.
`timescale 1ns/100ps
`default_nettype none
module ris_warmup_cnt #(
   parameter int WARMUP_CYC = ris_pkg::WARMUP_CYC_DEF
) (
   // Clock and reset
   input wire logic   clk,
   input wire logic   reset_n,
   // Control
   ris_ctl_if.cnt     ctl
);
   localparam int W = $clog2(WARMUP_CYC + 1);
   localparam logic [W-1:0] TERM = W'(WARMUP_CYC - 1);
   initial begin
      if (WARMUP_CYC < 2) $error("WARMUP_CYC must be at least 2");
   end
   logic [W-1:0] cnt_r, cnt_nxt;
   logic         run_r, run_nxt;
   logic         done_r, done_nxt;
   always_comb begin
      cnt_nxt  = cnt_r;
      run_nxt  = run_r;
      done_nxt = 1'b0;
      if (ctl.wu_clear) begin
         cnt_nxt = '0; // R7 R19
         run_nxt = 1'b1;
      end else if (run_r) begin
         if (cnt_r == TERM) begin
            run_nxt  = 1'b0; // R7
            done_nxt = 1'b1; // R21
         end else begin
            cnt_nxt = cnt_r + 1'b1; // R18
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_r  <= '0;
         run_r  <= 1'b1;
         done_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         run_r  <= run_nxt;
         done_r <= done_nxt;
      end
   end
   assign ctl.wu_done = done_r;
   property p_done_at_term;
      @(posedge clk) disable iff (!reset_n)
         (run_r && !ctl.wu_clear && cnt_r == TERM) |=> done_r;
   endproperty
   a_done_at_term: assert property (p_done_at_term) else $error("done missed"); // R21
   property p_clear_holds;
      @(posedge clk) disable iff (!reset_n)
         ctl.wu_clear |=> cnt_r == '0 && !done_r;
   endproperty
   a_clear_holds: assert property (p_clear_holds) else $error("counter not cleared"); // R19
   property p_cnt_stops;
      @(posedge clk) disable iff (!reset_n)
         (!run_r && !ctl.wu_clear) |=> ($stable(cnt_r) && !done_r);
   endproperty
   a_cnt_stops: assert property (p_cnt_stops) else $error("counter ran after end"); // R7
endmodule : ris_warmup_cnt
`default_nettype wire

// >>> hdl/ris_sequencer.sv
// Top of the reset and initialisation sequencer.
// Assumes por_active comes from the analog power-on detector, async to clk.
//
// How it works
// [R1] Hold PC at mode vector, SP 0x00FF
// [R2] Bank select forced zero until release
// [R3] Interrupt enables and latches held zero
// [R4] RAM, working registers and flags untouched
// [R5] Internal oscillator enabled at all times
// [R6] External oscillators disabled through warm-up
// [R7] Counter cleared in reset, stops at end
// [R8] Prescaler and divider held at zero
// [R9] Watchdog enabled once warm-up completes
// [R10] Port pins high impedance while held
// [R11] Voltage detect disabled only by POR/pin
// [R12] POR indication follows supply thresholds
// [R13] Shared pin defaults to reset function
// [R14] Internal reset is POR OR pin
// [R15] Warm-up starts at later source release
// [R16] CPU and peripherals held until done
// [R17] Partner holds pin low until supply stable
// [R18] Counter counts high-frequency clock cycles
// [R19] New reset during warm-up restarts count
// [R20] CPU starts from vector at 0xFFFE/0xFFFF
// [R21] Parameter sets length; one done pulse
`timescale 1ns/100ps
`default_nettype none
module ris_sequencer #(
   parameter int WARMUP_CYC = ris_pkg::WARMUP_CYC_DEF,
   parameter int NUM_INT    = ris_pkg::NUM_INT_DEF,
   parameter int NUM_PORT   = ris_pkg::NUM_PORT_DEF
) (
   // Clock and reset
   input  wire logic                clk,
   input  wire logic                reset_n,
   // Reset sources
   input  wire logic                por_active,
   input  wire logic                ext_reset_pin_n,
   input  wire logic                int_factor_reset,
   input  wire logic                reset_pin_as_port,
   input  wire logic                serial_prom_mode,
   // Software writes after release
   input  wire logic                vd_enable_wr,
   input  wire logic                vd_enable_val,
   // CPU state
   output logic [15:0]              program_counter,
   output logic [15:0]              stack_pointer,
   output logic [15:0]              reset_vector_lo_addr,
   output logic [15:0]              reset_vector_hi_addr,
   output logic [1:0]               register_bank_select,
   output logic                     interrupt_master_enable,
   output logic [NUM_INT-1:0]       interrupt_source_enable,
   output logic [NUM_INT-1:0]       interrupt_request_latch,
   // Clocks, timers, pins
   output logic                     int_hf_osc_en,
   output logic                     ext_hf_osc_en,
   output logic                     ext_lf_osc_en,
   output logic [7:0]               prescaler_clear_val,
   output logic                     prescaler_hold,
   output logic                     watchdog_en,
   output logic                     voltage_detect_en,
   output logic [NUM_PORT-1:0]      port_oe,
   output logic                     shared_reset_port_pin_is_reset,
   // Status
   output logic                     system_reset,
   output logic                     cpu_hold,
   output logic                     warmup_active,
   output logic                     warmup_done
);
   initial begin
      if (NUM_INT < 1 || NUM_PORT < 1) $error("NUM_INT and NUM_PORT must be positive");
   end

   // Synchronisers for asynchronous sources
   logic por_s1_r, por_s2_r, pin_s1_r, pin_s2_r;
   logic por_s1_nxt, pin_s1_nxt;
   always_comb begin
      por_s1_nxt = por_active;
      pin_s1_nxt = ext_reset_pin_n;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         por_s1_r <= 1'b1;
         por_s2_r <= 1'b1;
         pin_s1_r <= 1'b0;
         pin_s2_r <= 1'b0;
      end else begin
         por_s1_r <= por_s1_nxt;
         por_s2_r <= por_s1_r;
         pin_s1_r <= pin_s1_nxt;
         pin_s2_r <= pin_s1_r;
      end
   end

   // Pin function: reset until software turns it into a port
   logic pin_is_reset_r, pin_is_reset_nxt;
   always_comb begin
      pin_is_reset_nxt = pin_is_reset_r;
      if (por_s2_r)
         pin_is_reset_nxt = 1'b1; // R13
      else if (!cpu_hold)
         pin_is_reset_nxt = !reset_pin_as_port;
   end
   always_ff @(posedge clk) begin
      if (!reset_n)
         pin_is_reset_r <= 1'b1;
      else
         pin_is_reset_r <= pin_is_reset_nxt;
   end

   // Reset combination; releases at the later of the sources
   logic pin_rst, hard_rst, any_rst;
   assign pin_rst  = pin_is_reset_r && !pin_s2_r;
   assign hard_rst = por_s2_r || pin_rst; // R14 R12
   assign any_rst  = hard_rst || int_factor_reset; // R15

   ris_ctl_if ctl ();
   assign ctl.wu_clear = any_rst; // R7 R19

   ris_warmup_cnt #(
      .WARMUP_CYC (WARMUP_CYC)
   ) u_warmup (
      .clk     (clk),
      .reset_n (reset_n),
      .ctl     (ctl.cnt)
   );

   // Sequencer states
   ris_pkg::ris_state_t state_r, state_nxt;
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ris_pkg::RIS_RESET: begin
            if (!any_rst) state_nxt = ris_pkg::RIS_WARMUP;
         end
         ris_pkg::RIS_WARMUP: begin
            if (any_rst) state_nxt = ris_pkg::RIS_RESET; // R19
            else if (ctl.wu_done) state_nxt = ris_pkg::RIS_RUN; // R16
         end
         ris_pkg::RIS_RUN: begin
            if (any_rst) state_nxt = ris_pkg::RIS_RESET;
         end
      endcase
   end
   always_ff @(posedge clk) begin
      if (!reset_n)
         state_r <= ris_pkg::RIS_RESET;
      else
         state_r <= state_nxt;
   end
   assign ctl.hold = (state_r != ris_pkg::RIS_RUN);

   // Voltage detect: cleared only by power-on or pin reset
   logic vd_en_r, vd_en_nxt;
   always_comb begin
      vd_en_nxt = vd_en_r;
      if (hard_rst)
         vd_en_nxt = 1'b0; // R11
      else if (!ctl.hold && !any_rst && vd_enable_wr)
         vd_en_nxt = vd_enable_val;
   end
   always_ff @(posedge clk) begin
      if (!reset_n)
         vd_en_r <= 1'b0;
      else
         vd_en_r <= vd_en_nxt;
   end

   // Registered outputs
   logic hold_q_r, done_q_r, wdt_r, prom_r;
   logic hold_q_nxt, done_q_nxt, wdt_nxt, prom_nxt;
   always_comb begin
      hold_q_nxt = ctl.hold; // R16
      done_q_nxt = ctl.wu_done; // R21
      wdt_nxt    = wdt_r;
      if (ctl.hold && !ctl.wu_done)
         wdt_nxt = 1'b0; // R9
      else if (ctl.wu_done)
         wdt_nxt = 1'b1; // R9
      prom_nxt   = ctl.hold ? serial_prom_mode : prom_r;
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         hold_q_r <= 1'b1;
         done_q_r <= 1'b0;
         wdt_r    <= 1'b0;
         prom_r   <= 1'b0;
      end else begin
         hold_q_r <= hold_q_nxt;
         done_q_r <= done_q_nxt;
         wdt_r    <= wdt_nxt;
         prom_r   <= prom_nxt;
      end
   end

   // State forced while held; RAM and flags not touched here // R4
   assign program_counter = prom_r ? ris_pkg::PC_VEC_PROM : ris_pkg::PC_VEC_MCU; // R1
   assign stack_pointer   = ris_pkg::SP_RESET; // R1
   assign reset_vector_lo_addr = ris_pkg::PC_VEC_MCU; // R20
   assign reset_vector_hi_addr = ris_pkg::VEC_HI_ADDR; // R20
   assign register_bank_select = ris_pkg::RBS_RESET; // R2
   assign interrupt_master_enable = 1'b0; // R3
   assign interrupt_source_enable = '0; // R3
   assign interrupt_request_latch = '0; // R3
   assign int_hf_osc_en   = 1'b1; // R5 R18
   assign ext_hf_osc_en   = 1'b0; // R6
   assign ext_lf_osc_en   = 1'b0; // R6
   assign prescaler_clear_val = ris_pkg::PRESCALE_RESET; // R8
   assign prescaler_hold  = hold_q_r; // R8
   assign watchdog_en     = wdt_r; // R9
   assign voltage_detect_en = vd_en_r;
   assign port_oe         = '0; // R10
   assign shared_reset_port_pin_is_reset = pin_is_reset_r;
   assign system_reset    = any_rst;
   assign cpu_hold        = hold_q_r; // R16
   assign warmup_active   = (state_r == ris_pkg::RIS_WARMUP);
   assign warmup_done     = done_q_r;

   // Checks
   property p_hold_in_reset;
      @(posedge clk) disable iff (!reset_n) any_rst |=> ##1 cpu_hold;
   endproperty
   a_hold_in_reset: assert property (p_hold_in_reset) else $error("CPU not held in reset"); // R16
   property p_release_after_done;
      @(posedge clk) disable iff (!reset_n)
         (ctl.wu_done && !any_rst) |=> ##1 !cpu_hold;
   endproperty
   a_release_after_done: assert property (p_release_after_done) else $error("no release"); // R16
   property p_wdt_off_held;
      @(posedge clk) disable iff (!reset_n) (cpu_hold && !warmup_done) |-> !watchdog_en;
   endproperty
   a_wdt_off_held: assert property (p_wdt_off_held) else $error("watchdog on while held"); // R9
   property p_wdt_on_done;
      @(posedge clk) disable iff (!reset_n) warmup_done |-> watchdog_en;
   endproperty
   a_wdt_on_done: assert property (p_wdt_on_done) else $error("watchdog not enabled"); // R9
   property p_vd_cleared;
      @(posedge clk) disable iff (!reset_n) hard_rst |=> !voltage_detect_en;
   endproperty
   a_vd_cleared: assert property (p_vd_cleared) else $error("voltage detect not cleared"); // R11
   property p_vd_kept;
      @(posedge clk) disable iff (!reset_n)
         (int_factor_reset && !hard_rst) |=> voltage_detect_en == $past(voltage_detect_en);
   endproperty
   a_vd_kept: assert property (p_vd_kept) else $error("voltage detect changed"); // R11
   property p_or_reset;
      @(posedge clk) disable iff (!reset_n) (por_s2_r || pin_rst) |-> system_reset;
   endproperty
   a_or_reset: assert property (p_or_reset) else $error("reset OR broken"); // R14
   property p_warm_starts;
      @(posedge clk) disable iff (!reset_n)
         ($fell(any_rst) && state_r == ris_pkg::RIS_RESET) |=> warmup_active;
   endproperty
   a_warm_starts: assert property (p_warm_starts) else $error("warm-up did not start"); // R15
   property p_done_single;
      @(posedge clk) disable iff (!reset_n) warmup_done |=> !warmup_done;
   endproperty
   a_done_single: assert property (p_done_single) else $error("done not one pulse"); // R21
   property p_pc_vec;
      @(posedge clk) disable iff (!reset_n)
         (cpu_hold && !prom_r) |-> program_counter == ris_pkg::PC_VEC_MCU;
   endproperty
   a_pc_vec: assert property (p_pc_vec) else $error("PC vector wrong"); // R1
endmodule : ris_sequencer
`default_nettype wire

// >>> verif/ris_pin_driver.sv
// Model of the external supervisor that drives the active-low reset pin.
// Assumes supply_ok is high once supply and oscillation are stable.
`timescale 1ns/100ps
`default_nettype none
module ris_pin_driver #(
   parameter int SETTLE_CYC = 50
) (
   // Clock
   input  wire logic clk,
   // Supply state
   input  wire logic supply_ok,
   // Reset pin
   output var  logic pin_n
);
   int unsigned wait_r;
   // Pin low until stable, then at least SETTLE_CYC cycles (5 us) more
   initial begin
      pin_n  = 1'b0;
      wait_r = 0;
      forever begin
         @(posedge clk);
         if (!supply_ok) begin
            pin_n  <= 1'b0;
            wait_r <= 0;
         end else if (wait_r < SETTLE_CYC) begin
            wait_r <= wait_r + 1;
         end else begin
            pin_n <= 1'b1;
         end
      end
   end
endmodule : ris_pin_driver
`default_nettype wire

// >>> verif/reset_init_sequencer_tb.sv
// Self-checking bench for the reset and initialisation sequencer.
// Assumes the pin driver model stands in for the external supervisor.
`timescale 1ns/100ps
`default_nettype none
module reset_init_sequencer_tb;
   localparam int W = 8;
   logic        clk, reset_n, por_active, pin_n, int_factor_reset, reset_pin_as_port;
   logic        serial_prom_mode, vd_enable_wr, vd_enable_val, supply_ok;
   logic [15:0] program_counter, stack_pointer, reset_vector_lo_addr, reset_vector_hi_addr;
   logic [1:0]  register_bank_select;
   logic [24:0] interrupt_source_enable, interrupt_request_latch;
   logic [7:0]  prescaler_clear_val, port_oe;
   logic        interrupt_master_enable, int_hf_osc_en, ext_hf_osc_en, ext_lf_osc_en;
   logic        prescaler_hold, watchdog_en, voltage_detect_en, shared_reset_port_pin_is_reset;
   logic        system_reset, cpu_hold, warmup_active, warmup_done;
   int          bad_count, total_checks, cyc, n;

   ris_sequencer #(.WARMUP_CYC(W)) dut (
      .clk(clk), .reset_n(reset_n), .por_active(por_active), .ext_reset_pin_n(pin_n),
      .int_factor_reset(int_factor_reset), .reset_pin_as_port(reset_pin_as_port),
      .serial_prom_mode(serial_prom_mode), .vd_enable_wr(vd_enable_wr),
      .vd_enable_val(vd_enable_val), .program_counter(program_counter),
      .stack_pointer(stack_pointer), .reset_vector_lo_addr(reset_vector_lo_addr),
      .reset_vector_hi_addr(reset_vector_hi_addr), .register_bank_select(register_bank_select),
      .interrupt_master_enable(interrupt_master_enable),
      .interrupt_source_enable(interrupt_source_enable),
      .interrupt_request_latch(interrupt_request_latch), .int_hf_osc_en(int_hf_osc_en),
      .ext_hf_osc_en(ext_hf_osc_en), .ext_lf_osc_en(ext_lf_osc_en),
      .prescaler_clear_val(prescaler_clear_val), .prescaler_hold(prescaler_hold),
      .watchdog_en(watchdog_en), .voltage_detect_en(voltage_detect_en), .port_oe(port_oe),
      .shared_reset_port_pin_is_reset(shared_reset_port_pin_is_reset),
      .system_reset(system_reset), .cpu_hold(cpu_hold), .warmup_active(warmup_active),
      .warmup_done(warmup_done));

   ris_pin_driver u_pin (.clk(clk), .supply_ok(supply_ok), .pin_n(pin_n));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic conclude();
      $display("checks=%0d mismatches=%0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         conclude();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic check_static();
      chk(32'(program_counter), serial_prom_mode ? 32'h0000_1ffe : 32'h0000_fffe);
      chk(32'(stack_pointer), 32'h0000_00ff);
      chk(32'(register_bank_select), 32'h0000_0000);
      chk(32'({interrupt_master_enable, interrupt_source_enable}), 32'h0000_0000);
      chk(32'(interrupt_request_latch), 32'h0000_0000);
      chk(32'({int_hf_osc_en, ext_hf_osc_en, ext_lf_osc_en}), 32'h0000_0004);
      chk(32'({prescaler_clear_val, prescaler_hold ^ cpu_hold}), 32'h0000_0000);
      chk(32'(port_oe), 32'h0000_0000);
      chk({reset_vector_hi_addr, reset_vector_lo_addr}, 32'hffff_fffe);
   endtask : check_static

   // Counts cycles from a release to the done pulse, then checks the run state
   task automatic wait_done(output int cnt);
      cnt = 0;
      while (warmup_done !== 1'b1 && cnt < 60) begin
         @(posedge clk);
         #1;
         cnt++;
         if (cnt == 3) begin
            check_static();
            chk(32'({cpu_hold, watchdog_en}), 32'h0000_0002);
         end
      end
      chk(32'(cnt >= W && cnt <= W + 8), 32'h0000_0001);
      @(posedge clk);
      #1;
      chk(32'(warmup_done), 32'h0000_0000);
      repeat (3) @(posedge clk);
      #1;
      chk(32'({cpu_hold, watchdog_en, warmup_active}), 32'h0000_0002);
      check_static();
   endtask : wait_done

   initial begin
      reset_n = 1'b0;
      por_active = 1'b1;
      int_factor_reset = 1'b0;
      reset_pin_as_port = 1'b0;
      serial_prom_mode = 1'b0;
      vd_enable_wr = 1'b0;
      vd_enable_val = 1'b0;
      supply_ok = 1'b0;
      repeat (8) @(posedge clk);
      #1;
      check_static();
      chk(32'({system_reset, cpu_hold, watchdog_en, warmup_done,
               shared_reset_port_pin_is_reset, voltage_detect_en}), 32'h0000_0032);
      // Power-on releases first, pin later
      @(posedge clk);
      reset_n <= 1'b1;
      por_active <= 1'b0;
      repeat (10) @(posedge clk);
      #1;
      chk(32'({system_reset, cpu_hold}), 32'h0000_0003);
      @(posedge clk);
      supply_ok <= 1'b1;
      while (pin_n !== 1'b1) @(posedge clk);
      wait_done(n);
      // Internal reset keeps voltage detect, pin reset clears it
      @(posedge clk);
      vd_enable_wr <= 1'b1;
      vd_enable_val <= 1'b1;
      @(posedge clk);
      vd_enable_wr <= 1'b0;
      int_factor_reset <= 1'b1;
      @(posedge clk);
      int_factor_reset <= 1'b0;
      @(posedge clk);
      #1;
      chk(32'({voltage_detect_en, cpu_hold, watchdog_en}), 32'h0000_0006);
      wait_done(n);
      @(posedge clk);
      supply_ok <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk(32'({voltage_detect_en, system_reset, watchdog_en}), 32'h0000_0002);
      // Serial PROM mode, reset again in mid warm-up
      @(posedge clk);
      serial_prom_mode <= 1'b1;
      supply_ok <= 1'b1;
      while (pin_n !== 1'b1) @(posedge clk);
      repeat (W / 2 + 3) @(posedge clk);
      int_factor_reset <= 1'b1;
      @(posedge clk);
      int_factor_reset <= 1'b0;
      wait_done(n);
      // Pin high, power-on releases last
      @(posedge clk);
      por_active <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk(32'({system_reset, cpu_hold, watchdog_en, shared_reset_port_pin_is_reset}),
          32'h0000_000d);
      @(posedge clk);
      por_active <= 1'b0;
      wait_done(n);
      // Pin turned to port, power-on gives it back
      @(posedge clk);
      reset_pin_as_port <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk(32'(shared_reset_port_pin_is_reset), 32'h0000_0000);
      @(posedge clk);
      supply_ok <= 1'b0;
      repeat (5) @(posedge clk);
      #1;
      chk(32'({system_reset, cpu_hold}), 32'h0000_0000);
      @(posedge clk);
      por_active <= 1'b1;
      repeat (6) @(posedge clk);
      #1;
      chk(32'({shared_reset_port_pin_is_reset, system_reset}), 32'h0000_0003);
      conclude();
   end
endmodule : reset_init_sequencer_tb
`default_nettype wire
